// ---- src/can_bt_defines.svh ----
// Constants for the CAN bit timing logic: register indices, fields, resets.
// Assumes inclusion by bare name from every design file that needs it.
//
// Function
// - Sync segment fixed at one quantum.
// - Propagation segment one to eight quanta.
// - Phase 1 one-eight, phase 2 one-eight quanta.
// - Sample point at end of phase 1.
// - Optional triple sample with majority vote.
// - Processing time two quanta after sample.
// - Quantum is two times prescaler plus one.
// - Jump width equals field plus one.
// - Hard sync on falling edge while idle.
// - At most one synchronization per bit.
// - Only recessive-to-dominant edges synchronize.
// - Edge used only if previous sample differs.
// - Phase error measured relative to sync segment.
// - Small phase error acts as hard sync.
// - Large positive error lengthens phase 1 by width.
// - Large negative error shortens phase 2 by width.
// - Transmitter ignores positive phase errors.
// - Phase 2 from field or max(phase1, two).
// - Timing registers writable only in configuration mode.
// - Segment fields encode value plus one.
`ifndef CAN_BT_DEFINES_SVH
`define CAN_BT_DEFINES_SVH
// Register indices; byte address is four times the index.
`define CFG3_IDX       8'h28
`define CFG2_IDX       8'h29
`define CFG1_IDX       8'h2A
`define CTRL_IDX       8'h30
`define STAT_IDX       8'h31
// Field positions.
`define CFG1_JUMP_MSB  7
`define CFG1_JUMP_LSB  6
`define CFG1_PRE_MSB   5
`define CFG2_P2SEL_BIT 7
`define CFG2_TRIPLE    6
`define CFG2_PH1_MSB   5
`define CFG2_PH1_LSB   3
`define CFG2_PROP_MSB  2
`define CFG3_PH2_MSB   2
`define CFG3_IMPL_MASK 8'hC7
// Reset values.
`define CFG_RST        8'h00
`define CTRL_RST       1'b1
// Timing in quanta.
`define PROC_TQ        4'h2
`endif

// ---- src/can_bt_pkg.sv ----
// Types shared by the bit timing modules.
// Assumes nothing of its surroundings.
package can_bt_pkg;
    // Gray coded along sync, propagation, phase 1, phase 2.
    typedef enum logic [1:0] {
        SEG_SYNC = 2'b00,
        SEG_PROP = 2'b01,
        SEG_PH1  = 2'b11,
        SEG_PH2  = 2'b10
    } seg_t;
endpackage : can_bt_pkg

// ---- src/tq_tick_if.sv ----
// Quantum and half-quantum enable pulses from the prescaler to users.
// Assumes one clock for all parties.
`timescale 1ns/1ps
interface tq_tick_if;
    logic tq_tick;
    logic half_tick;
    modport gen (output tq_tick, output half_tick);
    modport use_side (input tq_tick, input half_tick);
endinterface : tq_tick_if

// ---- src/quantum_prescaler_gen.sv ----
// Time quantum divider: one tick every 2*(prescale+1) clocks.
// Assumes core_clk is the oscillator and restart is a one-cycle pulse.
`timescale 1ns/1ps
`include "can_bt_defines.svh"
module quantum_prescaler_gen (
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // Control.
    input  wire logic [5:0] prescale,
    input  wire logic       restart,
    // Ticks.
    tq_tick_if.gen          ticks
);
    logic [6:0] cnt;
    logic [6:0] next_cnt;
    logic [6:0] top;
    logic [6:0] gap;

    // Top count is 2*prescale+1, half tick halfway through.
    assign top             = {prescale, 1'b1};
    assign ticks.tq_tick   = (cnt == top);
    assign ticks.half_tick = (cnt == {1'b0, prescale});

    // Restart realigns the quantum with the synchronizing edge.
    always_comb begin
        if (restart || ticks.tq_tick) begin
            next_cnt = 7'h00;
        end else begin
            next_cnt = cnt + 7'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cnt <= 7'h00;
            gap <= 7'h00;
        end else begin
            cnt <= next_cnt;
            gap <= (restart || ticks.tq_tick) ? 7'h00 : gap + 7'h01;
        end
    end

    // A tick only ends a run of exactly top+1 clocks, and two ticks never touch,
    // which also covers the two-clock quantum of a zero prescaler.
    a_tq_period: assert property (@(posedge core_clk) disable iff (!rstn)
        ticks.tq_tick |-> gap == top)
        else $error("Quantum tick at wrong count.");
    a_tq_spacing: assert property (@(posedge core_clk) disable iff (!rstn)
        ticks.tq_tick |=> !ticks.tq_tick)
        else $error("Quantum tick repeated too soon.");
endmodule : quantum_prescaler_gen

// ---- src/majority_sampler.sv ----
// Keeps the two receive samples taken half a quantum apart ahead of the
// sample point and forms the bit value. Assumes the pin is synchronous.
`timescale 1ns/1ps
module majority_sampler (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic rstn,
    // Pin and control.
    input  wire logic rx,
    input  wire logic triple_en,
    tq_tick_if.use_side ticks,
    // Result.
    output logic      vote
);
    logic [1:0] hist;
    logic [1:0] next_hist;

    // Shift on every half quantum so the two latest are -1.0 and -0.5 TQ.
    always_comb begin
        if (ticks.tq_tick || ticks.half_tick) begin
            next_hist = {hist[0], rx};
        end else begin
            next_hist = hist;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            hist <= 2'b11;
        end else begin
            hist <= next_hist;
        end
    end

    // Majority of three, or the single present sample.
    assign vote = triple_en ? ((hist[1] & hist[0]) | (hist[1] & rx) | (hist[0] & rx))
                            : rx;

    a_vote_single: assert property (@(posedge core_clk) disable iff (!rstn)
        !triple_en |-> vote == rx)
        else $error("Single sample does not follow pin.");
endmodule : majority_sampler

// ---- src/can_bit_timing_logic.sv ----
// Bit timing and synchronization of a CAN node with an APB register port.
// Assumes bus_idle and transmitting come from the protocol logic in the
// same clock domain and that the receive pin is already synchronous.
`timescale 1ns/1ps
`include "can_bt_defines.svh"
module can_bit_timing_logic (
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Bus pin and protocol side.
    input  wire logic        bus_receive_pin,
    input  wire logic        bus_idle,
    input  wire logic        transmitting,
    output logic             rx_bit,
    output logic             rx_bit_valid
);
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0]  bit_timing_config_1;
    logic [7:0]  bit_timing_config_2;
    logic [7:0]  bit_timing_config_3;
    logic        config_mode;
    logic [7:0]  next_cfg1;
    logic [7:0]  next_cfg2;
    logic [7:0]  next_cfg3;
    logic        next_config_mode;
    logic [31:0] next_prdata;
    logic        wr;
    logic        mapped;
    logic [7:0]  idx;
    logic [7:0]  status_word;

    assign idx    = paddr[9:2];
    assign wr     = psel && penable && pwrite;
    assign pready = 1'b1;
    // Only word-aligned known indices answer without error.
    always_comb begin
        if (paddr[1:0] != 2'b00) begin
            mapped = 1'b0;
        end else if (idx == `CFG1_IDX || idx == `CFG2_IDX || idx == `CFG3_IDX) begin
            mapped = 1'b1;
        end else if (idx == `CTRL_IDX || idx == `STAT_IDX) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end
    assign pslverr = psel && penable && !mapped;

    // Timing writes outside configuration mode are dropped silently.
    always_comb begin
        next_cfg1        = bit_timing_config_1;
        next_cfg2        = bit_timing_config_2;
        next_cfg3        = bit_timing_config_3;
        next_config_mode = config_mode;
        if (wr && mapped && config_mode && idx == `CFG1_IDX) begin
            next_cfg1 = pwdata[7:0];
        end else if (wr && mapped && config_mode && idx == `CFG2_IDX) begin
            next_cfg2 = pwdata[7:0];
        end else if (wr && mapped && config_mode && idx == `CFG3_IDX) begin
            next_cfg3 = pwdata[7:0] & `CFG3_IMPL_MASK;
        end else if (wr && mapped && idx == `CTRL_IDX) begin
            next_config_mode = pwdata[0];
        end
    end

    // Read data is captured in the setup cycle so it comes from a flop.
    always_comb begin
        next_prdata = prdata;
        if (psel && !penable) begin
            if (paddr[1:0] != 2'b00) begin
                next_prdata = 32'h0000_0000;
            end else if (idx == `CFG1_IDX) begin
                next_prdata = {24'h000000, bit_timing_config_1};
            end else if (idx == `CFG2_IDX) begin
                next_prdata = {24'h000000, bit_timing_config_2};
            end else if (idx == `CFG3_IDX) begin
                next_prdata = {24'h000000, bit_timing_config_3};
            end else if (idx == `CTRL_IDX) begin
                next_prdata = {31'h0000_0000, config_mode};
            end else if (idx == `STAT_IDX) begin
                next_prdata = {24'h000000, status_word};
            end else begin
                next_prdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            bit_timing_config_1 <= `CFG_RST;
            bit_timing_config_2 <= `CFG_RST;
            bit_timing_config_3 <= `CFG_RST;
            config_mode         <= `CTRL_RST;
            prdata              <= 32'h0000_0000;
        end else begin
            bit_timing_config_1 <= next_cfg1;
            bit_timing_config_2 <= next_cfg2;
            bit_timing_config_3 <= next_cfg3;
            config_mode         <= next_config_mode;
            prdata              <= next_prdata;
        end
    end

    // ------------------------------------------------------------
    // Decoded lengths in quanta
    // ------------------------------------------------------------
    logic [5:0] quantum_prescaler;
    logic [3:0] jump_width;
    logic [3:0] prop_len;
    logic [3:0] ph1_len;
    logic [3:0] ps2_len;
    logic       triple_sample_en;
    logic       phase2_length_select;

    assign quantum_prescaler    = bit_timing_config_1[`CFG1_PRE_MSB:0];
    assign jump_width           = {2'b00, bit_timing_config_1[`CFG1_JUMP_MSB:`CFG1_JUMP_LSB]}
                                  + 4'h1;
    assign triple_sample_en     = bit_timing_config_2[`CFG2_TRIPLE];
    assign phase2_length_select = bit_timing_config_2[`CFG2_P2SEL_BIT];
    assign prop_len = {1'b0, bit_timing_config_2[`CFG2_PROP_MSB:0]} + 4'h1;
    assign ph1_len  = {1'b0, bit_timing_config_2[`CFG2_PH1_MSB:`CFG2_PH1_LSB]}
                      + 4'h1;
    // Without the select bit phase 2 follows phase 1 but never drops below
    // the processing time, so a one-quantum phase 1 still works.
    always_comb begin
        if (phase2_length_select) begin
            ps2_len = {1'b0, bit_timing_config_3[`CFG3_PH2_MSB:0]} + 4'h1;
        end else if (ph1_len > `PROC_TQ) begin
            ps2_len = ph1_len;
        end else begin
            ps2_len = `PROC_TQ;
        end
    end

    // ------------------------------------------------------------
    // Quantum divider and sampler
    // ------------------------------------------------------------
    tq_tick_if ticks ();
    logic restart;
    logic vote;

    quantum_prescaler_gen u_prescaler (
        .core_clk (core_clk),
        .rstn     (rstn),
        .prescale (quantum_prescaler),
        .restart  (restart),
        .ticks    (ticks.gen)
    );

    majority_sampler u_sampler (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .rx        (bus_receive_pin),
        .triple_en (triple_sample_en),
        .ticks     (ticks.use_side),
        .vote      (vote)
    );

    // ------------------------------------------------------------
    // Bit segment sequencer and synchronization
    // ------------------------------------------------------------
    can_bt_pkg::seg_t seg;
    can_bt_pkg::seg_t next_seg;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [3:0] ph1_ext;
    logic [3:0] next_ph1_ext;
    logic [3:0] ph2_cut;
    logic [3:0] next_ph2_cut;
    logic       synced;
    logic       next_synced;
    logic       bit_pend;
    logic       next_bit_pend;
    logic       next_rx_bit;
    logic       next_rx_bit_valid;
    logic       rx_prev;
    logic       fall_edge;
    logic       edge_ok;
    logic [3:0] ph1_end;
    logic [3:0] ph2_end;
    logic [4:0] err_pos;
    logic [3:0] err_neg;
    logic       sample_now;

    // Recessive is high; only a high-to-low step may synchronize, and only
    // when the last sampled bit was recessive.
    assign fall_edge = rx_prev && !bus_receive_pin;
    assign edge_ok   = fall_edge && rx_bit;
    assign ph1_end   = ph1_len + ph1_ext;
    assign ph2_end   = ps2_len - ph2_cut;
    // Positive error counts quanta since sync ended, negative counts the
    // quanta still left in phase 2.
    always_comb begin
        if (seg == can_bt_pkg::SEG_PROP) begin
            err_pos = {1'b0, cnt} + 5'h01;
        end else begin
            err_pos = {1'b0, prop_len} + {1'b0, cnt} + 5'h01;
        end
    end
    assign err_neg    = ph2_end - cnt;
    assign sample_now = ticks.tq_tick && seg == can_bt_pkg::SEG_PH1
                        && cnt == ph1_end - 4'h1;

    // Next-state logic; a restart beats the quantum tick.
    always_comb begin
        next_seg          = seg;
        next_cnt          = cnt;
        next_ph1_ext      = ph1_ext;
        next_ph2_cut      = ph2_cut;
        next_synced       = synced;
        next_bit_pend     = bit_pend;
        next_rx_bit       = rx_bit;
        next_rx_bit_valid = 1'b0;
        restart           = 1'b0;
        if (edge_ok && !synced) begin
            if (bus_idle) begin
                restart = 1'b1;
            end else begin
                case (seg)
                    can_bt_pkg::SEG_SYNC: begin
                        next_synced = 1'b1;
                    end
                    can_bt_pkg::SEG_PROP, can_bt_pkg::SEG_PH1: begin
                        if (transmitting) begin
                            next_synced = synced;
                        end else if (err_pos <= {1'b0, jump_width}) begin
                            restart = 1'b1;
                        end else begin
                            next_ph1_ext = jump_width;
                            next_synced  = 1'b1;
                        end
                    end
                    default: begin
                        if (err_neg <= jump_width) begin
                            restart = 1'b1;
                        end else begin
                            next_ph2_cut = jump_width;
                            next_synced  = 1'b1;
                        end
                    end
                endcase
            end
        end
        if (restart) begin
            next_seg          = can_bt_pkg::SEG_SYNC;
            next_cnt          = 4'h0;
            next_ph1_ext      = 4'h0;
            next_ph2_cut      = 4'h0;
            next_synced       = 1'b1;
            next_bit_pend     = 1'b0;
            next_rx_bit_valid = bit_pend;
        end else if (ticks.tq_tick) begin
            next_cnt = cnt + 4'h1;
            case (seg)
                can_bt_pkg::SEG_SYNC: begin
                    next_seg = can_bt_pkg::SEG_PROP;
                    next_cnt = 4'h0;
                end
                can_bt_pkg::SEG_PROP: begin
                    if (cnt == prop_len - 4'h1) begin
                        next_seg = can_bt_pkg::SEG_PH1;
                        next_cnt = 4'h0;
                    end
                end
                can_bt_pkg::SEG_PH1: begin
                    if (sample_now) begin
                        next_seg      = can_bt_pkg::SEG_PH2;
                        next_cnt      = 4'h0;
                        next_rx_bit   = vote;
                        next_bit_pend = 1'b1;
                        next_ph1_ext  = 4'h0;
                    end
                end
                default: begin
                    if (bit_pend && cnt == `PROC_TQ - 4'h1) begin
                        next_rx_bit_valid = 1'b1;
                        next_bit_pend     = 1'b0;
                    end
                    if (cnt == ph2_end - 4'h1) begin
                        next_seg          = can_bt_pkg::SEG_SYNC;
                        next_cnt          = 4'h0;
                        next_ph2_cut      = 4'h0;
                        next_synced       = 1'b0;
                        next_bit_pend     = 1'b0;
                        next_rx_bit_valid = bit_pend || next_rx_bit_valid;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            seg          <= can_bt_pkg::SEG_SYNC;
            cnt          <= 4'h0;
            ph1_ext      <= 4'h0;
            ph2_cut      <= 4'h0;
            synced       <= 1'b0;
            bit_pend     <= 1'b0;
            rx_bit       <= 1'b1;
            rx_bit_valid <= 1'b0;
            rx_prev      <= 1'b1;
        end else begin
            seg          <= next_seg;
            cnt          <= next_cnt;
            ph1_ext      <= next_ph1_ext;
            ph2_cut      <= next_ph2_cut;
            synced       <= next_synced;
            bit_pend     <= next_bit_pend;
            rx_bit       <= next_rx_bit;
            rx_bit_valid <= next_rx_bit_valid;
            rx_prev      <= bus_receive_pin;
        end
    end

    assign status_word = {2'b00, seg, synced, bit_pend, config_mode, rx_bit};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sync_one_tq: assert property (@(posedge core_clk) disable iff (!rstn)
        seg == can_bt_pkg::SEG_SYNC && ticks.tq_tick && !restart |=> seg == can_bt_pkg::SEG_PROP)
        else $error("Sync segment longer than one quantum.");
    a_cfg_locked: assert property (@(posedge core_clk) disable iff (!rstn)
        wr && !config_mode |=> $stable(bit_timing_config_1) && $stable(bit_timing_config_2)
        && $stable(bit_timing_config_3))
        else $error("Timing register changed outside configuration mode.");
    a_hard_restart: assert property (@(posedge core_clk) disable iff (!rstn)
        edge_ok && !synced && bus_idle |=> seg == can_bt_pkg::SEG_SYNC && cnt == 4'h0 && synced)
        else $error("Idle edge did not restart the bit.");
    a_one_sync: assert property (@(posedge core_clk) disable iff (!rstn)
        restart |=> synced)
        else $error("Second synchronization in one bit.");
    a_rise_ignored: assert property (@(posedge core_clk) disable iff (!rstn)
        !rx_prev && bus_receive_pin |-> !restart && (synced || !next_synced))
        else $error("Rising edge used for synchronization.");
    a_tx_no_pos: assert property (@(posedge core_clk) disable iff (!rstn)
        transmitting && !bus_idle && (seg == can_bt_pkg::SEG_PROP || seg == can_bt_pkg::SEG_PH1)
        |-> !restart)
        else $error("Transmitter resynchronized on positive error.");
    a_ext_width: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(ph1_ext != 4'h0) |-> ph1_ext == jump_width)
        else $error("Phase 1 lengthened by wrong amount.");
    a_cut_width: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(ph2_cut != 4'h0) |-> ph2_cut == jump_width)
        else $error("Phase 2 shortened by wrong amount.");
    a_bit_after_ipt: assert property (@(posedge core_clk) disable iff (!rstn)
        sample_now && !restart |=> bit_pend ##[1:300] rx_bit_valid)
        else $error("Sampled bit not handed on in time.");
endmodule : can_bit_timing_logic

// ---- tb/can_node_model.sv ----
// Far-side CAN node: drives the receive line with whole bits of fixed length.
// Assumes the caller starts a frame just after a rising clock edge.
`timescale 1ns/1ps
module can_node_model (
    // Clock.
    input  wire logic core_clk,
    // Bus line seen by the device.
    output logic      rxd
);
    // The line idles recessive, as the bus termination pulls it there.
    initial rxd = 1'b1;

    // Bits change only at bit starts, so each edge lands in the sync segment.
    task automatic send(input logic [15:0] bits, input int n, input int clks);
        for (int i = n - 1; i >= 0; i--) begin
            rxd <= bits[i];
            repeat (clks) @(posedge core_clk);
        end
        rxd <= 1'b1;
    endtask : send
endmodule : can_node_model

// ---- tb/tb.sv ----
// Self-checking bench: APB register checks and bit reception from a node.
// Assumes the design files and can_node_model are compiled first.
`timescale 1ns/1ps
`include "can_bt_defines.svh"
module tb;
    logic        core_clk, rstn, psel, penable, pwrite, bus_idle, transmitting;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, rxd, rx_bit, rx_bit_valid;
    logic [32:0] rd_q[$];
    logic        bit_q[$];
    int          miscompares = 0, n_compared = 0, seed = 32'h3880FC68, q, n;
    logic [15:0] frame;

    can_bit_timing_logic uut (.core_clk(core_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_receive_pin(rxd),
        .bus_idle(bus_idle), .transmitting(transmitting), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid));
    can_node_model node (.core_clk(core_clk), .rxd(rxd));

    // Clock at 100 MHz.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic end_sim;
        if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task automatic chk_rd(input logic [32:0] e, input logic [32:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t read exp %h got %h", $time, e, g);
        end
    endtask : chk_rd

    task automatic chk_bit(input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t bit exp %h got %h", $time, e, g);
        end
    endtask : chk_bit

    // One APB transfer; waits for pready under a bound, then idles a cycle.
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            miscompares++;
            end_sim();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    // Notes the expected {error, data} of a read, then performs it.
    task automatic rd(input logic [9:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // Results are taken off the queues as the design presents them.
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
            chk_rd(rd_q.pop_front(), {pslverr, prdata});
        if (rx_bit_valid === 1'b1 && bit_q.size() > 0)
            chk_bit(bit_q.pop_front(), rx_bit);
    end

    // A hang anywhere counts as a mismatch.
    initial begin
        #200us;
        miscompares++;
        end_sim();
    end

    initial begin
        rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 10'h0;
        pwdata = 32'h0; bus_idle = 1'b1; transmitting = 1'b0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rd({`CFG1_IDX, 2'b00}, 33'h0);
        rd({`CFG2_IDX, 2'b00}, 33'h0);
        rd({`CFG3_IDX, 2'b00}, 33'h0);
        rd({`CTRL_IDX, 2'b00}, 33'h1);
        rd(10'h3FC, 33'h1_0000_0000);
        rd(10'h0A9, 33'h1_0000_0000);
        apb(1'b1, {`CFG3_IDX, 2'b00}, 32'hFF);
        rd({`CFG3_IDX, 2'b00}, {25'h0, `CFG3_IMPL_MASK});
        for (int p = 0; p < 2; p++) begin
            q = 2 * (($random(seed) & 3) + 1);
            // Segments kept legal by the host: prop 1 or 2, ph1 1, ph2 2 or 3
            // quanta, so prop plus ph1 never falls below ph2.
            apb(1'b1, {`CTRL_IDX, 2'b00}, 32'h1);
            apb(1'b1, {`CFG1_IDX, 2'b00}, q / 2 - 1);
            apb(1'b1, {`CFG2_IDX, 2'b00}, p ? 32'hC1 : 32'h0);
            apb(1'b1, {`CFG3_IDX, 2'b00}, p ? 32'h02 : 32'h0);
            apb(1'b1, {`CTRL_IDX, 2'b00}, 32'h0);
            apb(1'b1, {`CFG1_IDX, 2'b00}, 32'hFF);
            rd({`CFG1_IDX, 2'b00}, q / 2 - 1);
            transmitting <= p[0];
            frame = {1'b0, 10'($random(seed)), 5'h0};
            n = 5 + 2 * p;
            fork
                node.send({5'h00, frame[15:5]}, 11, n * q);
                begin
                    repeat (3) @(posedge core_clk);
                    bus_idle <= 1'b0;
                    for (int i = 15; i >= 5; i--) bit_q.push_back(frame[i]);
                end
            join
            for (int k = 0; k < 400 && bit_q.size() > 0; k++) @(posedge core_clk);
            if (bit_q.size() > 0) begin
                miscompares++;
                end_sim();
            end
            bus_idle <= 1'b1;
            repeat (20) @(posedge core_clk);
        end
        end_sim();
    end
endmodule : tb
